// >>> core/lan_map.svh
`ifndef LAN_MAP_SVH
`define LAN_MAP_SVH

// Register byte offsets (low address bits)
`define LAN_OFS_CTRL    4'h0
`define LAN_OFS_SEL     4'h4
`define LAN_OFS_ACK     4'h8
`define LAN_OFS_STATUS  4'hc

// Control register fields
`define LAN_CTRL_LATCH  0
`define LAN_CTRL_ACT_LO 1
`define LAN_CTRL_INA_LO 4
`define LAN_CTRL_INV_LO 7

// Reset values: latch off, active red, inactive off, no inversion, nothing assigned
`define LAN_CTRL_RST    32'h0000_0004
`define LAN_SEL_RST     32'h0000_0000
`define LAN_ACK_RST     32'h0000_0000

// Status register fields
`define LAN_ST_COMB     0
`define LAN_ST_LATCHED  1
`define LAN_ST_RED      2
`define LAN_ST_GREEN    3
`define LAN_ST_PHASE    4

// AXI responses
`define LAN_RESP_OKAY   2'b00
`define LAN_RESP_SLVERR 2'b10

`endif

// >>> core/lan_pkg.sv
package lan_pkg;

  // Lamp colour codes, in field order 0..4; codes 5..7 act as dark
  typedef enum logic [2:0] {
    LAN_COL_OFF,
    LAN_COL_GREEN,
    LAN_COL_RED,
    LAN_COL_RED_FLASH,
    LAN_COL_GREEN_FLASH
  } lan_colour_type;

endpackage

// >>> core/lan_top.sv
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "lan_map.svh"

// How it works
// [RQ1] A latch setting, off after reset, keeps the lamp lit after the combined input drops.
// [RQ2] The acknowledge selection only has an effect while the latch setting is on.
// [RQ3] An acknowledge clears the held lamp only when the combined input is false, else ignored.
// [RQ4] While the combined input is true the lamp shows the active colour, red after reset.
// [RQ5] While the combined input is false and nothing is held the lamp shows the inactive colour, dark after reset.
// [RQ6] Five slots each pick a signal and may invert it before the OR, inversion off at reset.
// [RQ7] A slot with no signal picked adds false to the OR whatever its inversion.
module lan_top
  import lan_pkg::*;
#(
  parameter int N_SIG     = 31,
  parameter int FLASH_CYC = 50000000
) (
  input  wire logic             CLK,
  input  wire logic             SRST,
  input  wire logic [N_SIG-1:0] SIG,
  input  wire logic             AWVALID,
  output logic                  AWREADY,
  input  wire logic [3:0]       AWADDR,
  input  wire logic             WVALID,
  output logic                  WREADY,
  input  wire logic [31:0]      WDATA,
  input  wire logic [3:0]       WSTRB,
  output logic                  BVALID,
  input  wire logic             BREADY,
  output logic [1:0]            BRESP,
  input  wire logic             ARVALID,
  output logic                  ARREADY,
  input  wire logic [3:0]       ARADDR,
  output logic                  RVALID,
  input  wire logic             RREADY,
  output logic [31:0]           RDATA,
  output logic [1:0]            RRESP,
  output logic                  LED_RED,
  output logic                  LED_GREEN
);

  localparam int NSLOT = 5;

  logic [31:0]          ctrl;
  logic [31:0]          sel;
  logic [31:0]          ack;
  logic                 aw_held;
  logic                 w_held;
  logic [3:0]           waddr;
  logic [31:0]          wdata;
  logic [3:0]           wstrb;
  logic                 do_write;
  logic                 latched;
  logic                 combined;
  logic                 lit;
  logic                 ack_hit;
  logic                 latch_en;
  logic                 phase;
  logic [31:0]          flash_cnt;
  logic [NSLOT-1:0]     slot_val;
  logic [NSLOT-1:0]     inv;
  logic [4:0]           ack_sel;
  lan_colour_type       act_col;
  lan_colour_type       ina_col;
  lan_colour_type       cur_col;
  logic                 next_red;
  logic                 next_green;
  logic [31:0]          rd_mux;

  assign latch_en = ctrl[`LAN_CTRL_LATCH];
  assign act_col  = lan_colour_type'(ctrl[`LAN_CTRL_ACT_LO +: 3]);
  assign ina_col  = lan_colour_type'(ctrl[`LAN_CTRL_INA_LO +: 3]);
  assign inv      = ctrl[`LAN_CTRL_INV_LO +: NSLOT];
  assign ack_sel  = ack[4:0];

  // Each slot: code 0 means unassigned, code k picks SIG[k-1]
  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      logic [4:0] code;
      assign code = sel[5*g +: 5];
      always_comb begin
        if (code == 5'h00 || int'(code) > N_SIG) begin
          slot_val[g] = 1'b0; // RQ7
        end else begin
          slot_val[g] = SIG[int'(code) - 1] ^ inv[g]; // RQ6
        end
      end
    end
  endgenerate

  assign combined = |slot_val; // RQ6

  // Acknowledge only counts with latching on and a signal picked
  always_comb begin
    if (!latch_en || ack_sel == 5'h00 || int'(ack_sel) > N_SIG) begin
      ack_hit = 1'b0; // RQ2
    end else begin
      ack_hit = SIG[int'(ack_sel) - 1];
    end
  end

  // Held indication; pickup wins over an acknowledge in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST || !latch_en) begin
      latched <= 1'b0; // RQ1
    end else if (combined) begin
      latched <= 1'b1; // RQ1 RQ3
    end else if (ack_hit) begin
      latched <= 1'b0; // RQ3
    end
  end

  assign lit = combined | latched;

  // Shared flash time base; one half period on, one off
  always_ff @(posedge CLK) begin
    if (SRST) begin
      flash_cnt <= 32'h0000_0000;
      phase     <= 1'b0;
    end else if (flash_cnt >= 32'(FLASH_CYC - 1)) begin
      flash_cnt <= 32'h0000_0000;
      phase     <= ~phase;
    end else begin
      flash_cnt <= flash_cnt + 32'h0000_0001;
    end
  end

  // Colour decode; unknown codes stay dark rather than guess
  always_comb begin
    cur_col    = lit ? act_col : ina_col; // RQ4 RQ5
    next_red   = 1'b0;
    next_green = 1'b0;
    case (cur_col)
      LAN_COL_GREEN:       next_green = 1'b1;
      LAN_COL_RED:         next_red   = 1'b1;
      LAN_COL_RED_FLASH:   next_red   = phase;
      LAN_COL_GREEN_FLASH: next_green = phase;
      default: begin
        next_red   = 1'b0;
        next_green = 1'b0;
      end
    endcase
  end

  // Lamp drivers are registered to keep glitches off the pins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      LED_RED   <= 1'b0;
      LED_GREEN <= 1'b0;
    end else begin
      LED_RED   <= next_red;
      LED_GREEN <= next_green;
    end
  end

  // Write address and data are taken independently, in either order
  assign do_write = aw_held && w_held && !BVALID;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      AWREADY <= 1'b0;
      aw_held <= 1'b0;
      waddr   <= 4'h0;
    end else if (AWVALID && AWREADY) begin
      AWREADY <= 1'b0;
      aw_held <= 1'b1;
      waddr   <= AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!AWREADY && !aw_held && !BVALID) begin
      AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WREADY <= 1'b0;
      w_held <= 1'b0;
      wdata  <= 32'h0000_0000;
      wstrb  <= 4'h0;
    end else if (WVALID && WREADY) begin
      WREADY <= 1'b0;
      w_held <= 1'b1;
      wdata  <= WDATA;
      wstrb  <= WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!WREADY && !w_held && !BVALID) begin
      WREADY <= 1'b1;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge CLK) begin
    if (SRST) begin
      BVALID <= 1'b0;
      BRESP  <= `LAN_RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP  <= (waddr[1:0] != 2'b00 || waddr > `LAN_OFS_STATUS) ?
                `LAN_RESP_SLVERR : `LAN_RESP_OKAY;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Configuration registers with byte strobes; status ignores writes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl <= `LAN_CTRL_RST; // RQ1 RQ4 RQ5 RQ6
      sel  <= `LAN_SEL_RST;
      ack  <= `LAN_ACK_RST;
    end else if (do_write) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb[b]) begin
          case (waddr)
            `LAN_OFS_CTRL: ctrl[8*b +: 8] <= wdata[8*b +: 8];
            `LAN_OFS_SEL:  sel[8*b +: 8]  <= wdata[8*b +: 8];
            `LAN_OFS_ACK:  ack[8*b +: 8]  <= wdata[8*b +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  // Read mux; unused bits of each field read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ARADDR)
      `LAN_OFS_CTRL: rd_mux[11:0] = ctrl[11:0];
      `LAN_OFS_SEL:  rd_mux[24:0] = sel[24:0];
      `LAN_OFS_ACK:  rd_mux[4:0]  = ack[4:0];
      `LAN_OFS_STATUS: begin
        rd_mux[`LAN_ST_COMB]    = combined;
        rd_mux[`LAN_ST_LATCHED] = latched;
        rd_mux[`LAN_ST_RED]     = LED_RED;
        rd_mux[`LAN_ST_GREEN]   = LED_GREEN;
        rd_mux[`LAN_ST_PHASE]   = phase;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= `LAN_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_mux;
      RRESP   <= (ARADDR[1:0] != 2'b00) ? `LAN_RESP_SLVERR : `LAN_RESP_OKAY;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end else if (!ARREADY && !RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  // Checks
  latch_hold_a: assert property (@(posedge CLK) disable iff (SRST) // RQ1
    latch_en && $past(latch_en) && $fell(combined) |-> latched)
    else $error("held lamp lost when input dropped");

  latch_off_a: assert property (@(posedge CLK) disable iff (SRST) // RQ1
    !latch_en |=> !latched || latch_en)
    else $error("lamp held with latching off");

  ack_gate_a: assert property (@(posedge CLK) disable iff (SRST) // RQ2
    latched && latch_en && !combined && ack_sel == 5'h00 |=> latched)
    else $error("held lamp cleared without acknowledge selected");

  ack_clear_a: assert property (@(posedge CLK) disable iff (SRST) // RQ3
    latched && latch_en && !combined && ack_hit |=> !latched)
    else $error("acknowledge did not clear held lamp");

  ack_ignore_a: assert property (@(posedge CLK) disable iff (SRST) // RQ3
    latch_en && combined ##1 latch_en |-> latched)
    else $error("held lamp cleared while input active");

  led_active_a: assert property (@(posedge CLK) disable iff (SRST) // RQ4
    combined && act_col == LAN_COL_RED |=> LED_RED && !LED_GREEN)
    else $error("active red not shown");

  led_inactive_a: assert property (@(posedge CLK) disable iff (SRST) // RQ5
    !lit && ina_col == LAN_COL_GREEN |=> LED_GREEN && !LED_RED)
    else $error("inactive green not shown");

  slot_invert_a: assert property (@(posedge CLK) disable iff (SRST) // RQ6
    sel[24:0] == 25'h0000001 |-> combined == (SIG[0] ^ inv[0]))
    else $error("slot inversion wrong");

  slot_empty_a: assert property (@(posedge CLK) disable iff (SRST) // RQ7
    sel[24:0] == 25'h0000000 |-> !combined)
    else $error("empty slots gave true");

endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
`include "lan_map.svh"

module tb
  import lan_pkg::*;
;
  localparam int NS = 31;
  logic          CLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic          AWREADY, WREADY, BVALID, ARREADY, RVALID, LED_RED, LED_GREEN;
  logic [NS-1:0] SIG;
  logic [3:0]    AWADDR, ARADDR, WSTRB;
  logic [31:0]   WDATA, RDATA, rv, seed;
  logic [1:0]    BRESP, RRESP, rs;
  int            mismatches, checks;

  // Flash half period cut to 4 cycles so flashing shows in a short run
  lan_top #(.N_SIG(NS), .FLASH_CYC(4)) uut (.CLK, .SRST, .SIG, .AWVALID, .AWREADY,
    .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID,
    .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP, .LED_RED, .LED_GREEN);

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task final_report;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Both channels offered together; each released once taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWVALID <= 1'b1;
    AWADDR  <= a;
    WVALID  <= 1'b1;
    WDATA   <= d;
    BREADY  <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!(BVALID && BREADY));
    BREADY <= 1'b0;
    rs = BRESP;
  endtask

  task rd(input logic [3:0] a);
    @(posedge CLK);
    ARVALID <= 1'b1;
    ARADDR  <= a;
    RREADY  <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!(RVALID && RREADY));
    RREADY <= 1'b0;
    rv = RDATA;
    rs = RRESP;
  endtask

  // Three edges let a held lamp clear: one for the latch, one for the lamp
  task sg(input logic [NS-1:0] v);
    @(posedge CLK);
    SIG <= v;
    repeat (3) @(posedge CLK);
  endtask

  task lamp(input logic r, input logic g);
    chk({30'h0, LED_GREEN, LED_RED}, {30'h0, g, r}, "lamp");
  endtask

  // Flashing: the lit colour must both show and go dark, the other stays off
  task ex(input int c);
    int nr, ng;
    nr = 0;
    ng = 0;
    repeat (16) @(posedge CLK) begin
      nr += LED_RED;
      ng += LED_GREEN;
    end
    if (c == 3) chk({31'h0, nr > 0 && nr < 16 && ng == 0}, 1, "red flash");
    else if (c == 4) chk({31'h0, ng > 0 && ng < 16 && nr == 0}, 1, "green flash");
    else lamp(c == 2, c == 1);
  endtask

  function logic [31:0] cw(input logic l, input logic [2:0] a, input logic [2:0] i,
                           input logic [4:0] v);
    return {20'h0, v, i, a, l};
  endfunction

  function logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected OR of the five slots; slot code 0 adds nothing
  function logic cb(input logic [24:0] sel, input logic [4:0] inv, input logic [NS-1:0] s);
    int k;
    cb = 1'b0;
    for (int i = 0; i < 5; i++) begin
      k = sel[5*i +: 5];
      if (k != 0) cb |= s[k-1] ^ inv[i];
    end
  endfunction

  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    final_report;
  end

  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    {AWADDR, ARADDR, WDATA} = '0;
    WSTRB = 4'hf;
    SIG   = '0;
    seed  = 32'h138e98d6;
    SRST  = 1'b1;
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    rd(`LAN_OFS_CTRL);
    chk(rv, 32'h0000_0004, "ctrl reset");
    chk({30'h0, rs}, {30'h0, `LAN_RESP_OKAY}, "read resp");
    rd(`LAN_OFS_SEL);
    chk(rv, 32'h0, "sel reset");
    wr(4'h2, 32'h0000_0ff1);
    chk({30'h0, rs}, {30'h0, `LAN_RESP_SLVERR}, "unaligned");
    rd(`LAN_OFS_CTRL);
    chk(rv, 32'h0000_0004, "ctrl kept");
    // Only byte lane 1 may land: it sets the upper four inversion bits
    WSTRB <= 4'h2;
    wr(`LAN_OFS_CTRL, 32'hffff_ffff);
    WSTRB <= 4'hf;
    chk({30'h0, rs}, {30'h0, `LAN_RESP_OKAY}, "write resp");
    rd(`LAN_OFS_CTRL);
    chk(rv, 32'h0000_0f04, "byte lane");
    rd(4'h6);
    chk({30'h0, rs}, {30'h0, `LAN_RESP_SLVERR}, "unaligned read");
    chk(rv, 32'h0, "unaligned read data");
    lamp(0, 0);
    $display("test reset done");
    wr(`LAN_OFS_SEL, 32'h1);
    // Code 5 is outside the colour list and must stay dark
    for (int c = 0; c < 6; c++) begin
      wr(`LAN_OFS_CTRL, cw(0, c, 0, 0));
      sg(1);
      ex(c);
      wr(`LAN_OFS_CTRL, cw(0, 0, c, 0));
      sg(0);
      ex(c);
    end
    $display("test colours done");
    wr(`LAN_OFS_CTRL, cw(0, 2, 0, 5'h01));
    sg(0);
    lamp(1, 0);
    rd(`LAN_OFS_STATUS);
    chk(rv & 32'hf, 32'h5, "status");
    sg(1);
    lamp(0, 0);
    wr(`LAN_OFS_SEL, 32'h0);
    wr(`LAN_OFS_CTRL, cw(0, 2, 0, 5'h1f));
    sg(0);
    lamp(0, 0);
    $display("test invert done");
    wr(`LAN_OFS_SEL, 32'h1);
    wr(`LAN_OFS_CTRL, cw(1, 2, 0, 0));
    sg(1);
    sg(0);
    lamp(1, 0);
    sg(2);
    lamp(1, 0);
    wr(`LAN_OFS_ACK, 32'h2);
    sg(1);
    sg(3);
    sg(0);
    lamp(1, 0);
    sg(2);
    lamp(0, 0);
    sg(1);
    sg(0);
    wr(`LAN_OFS_CTRL, cw(0, 2, 0, 0));
    sg(2);
    lamp(0, 0);
    $display("test latch done");
    // Short reset in mid-run must bring back every default
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rd(`LAN_OFS_CTRL);
    chk(rv, 32'h0000_0004, "ctrl reset again");
    rd(`LAN_OFS_ACK);
    chk(rv, 32'h0, "ack reset");
    lamp(0, 0);
    $display("test reset again done");
    for (int n = 0; n < 40; n++) begin
      logic [31:0] s, v;
      seed = lf(seed);
      s = seed;
      seed = lf(seed);
      v = seed;
      wr(`LAN_OFS_SEL, {7'h0, s[24:0]});
      wr(`LAN_OFS_CTRL, cw(0, 2, 0, v[4:0]));
      seed = lf(seed);
      sg(seed[NS-1:0]);
      lamp(cb(s[24:0], v[4:0], seed[NS-1:0]), 0);
    end
    $display("test random done");
    final_report;
  end
endmodule
